/* File: dv/fis_field_model.sv */
`default_nettype none
// ==========================================================
// Far side: Hall switch, converter, DAC and input switch
module fis_field_model #(
  parameter int REFRESH = 30
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench knobs
  input wire logic flux_on,
  input wire logic [3:0] lat,
  input wire logic [8:0] i_amp,
  input wire logic [8:0] v_amp,
  input wire logic [8:0] t_amp,
  // Block side
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  input wire logic ana_sel,
  input wire logic dac_req,
  output logic adc_done,
  output logic [9:0] adc_data,
  output logic dac_ack,
  output logic magnet_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rc;
  logic [3:0] cnt;
  logic [4:0] dcnt;
  logic busy;
  logic sgn;
  logic volt;
  logic [8:0] amp;
  // Select low routes the line, high the test waveform
  assign amp = volt ? v_amp : (ana_sel ? t_amp : i_amp);
  // Field seen once per refresh only; pull-up when released
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc <= 8'h00;
      magnet_n <= 1'b1;
    end else if (rc == 8'(REFRESH - 1)) begin
      rc <= 8'h00;
      magnet_n <= !flux_on;
    end else begin
      rc <= rc + 8'h01;
    end
  end
  // Square wave around mid-code; data churns when not valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      sgn <= 1'b0;
      volt <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 10'h000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start) begin
        busy <= 1'b1;
        cnt <= lat;
        volt <= adc_chan == 2'h2;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        sgn <= ~sgn;
        adc_data <= sgn ? 10'h200 - {1'b0, amp} : 10'h200 + {1'b0, amp};
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // One ack per request, lat+1 cycles after it rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt <= 5'h00;
      dac_ack <= 1'b0;
    end else begin
      dac_ack <= dac_req && dcnt == {1'b0, lat};
      if (!dac_req) dcnt <= 5'h00;
      else if (dcnt != 5'h1f) dcnt <= dcnt + 5'h01;
    end
  end
endmodule // fis_field_model
`default_nettype wire

/* File: dv/fis_seq_props.sv */
`default_nettype none
// ==========================================================
// Port-level checks of the mode sequencer
module fis_seq_props #(
  parameter PERIOD_CYC = 1000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Field and board
  input wire logic magnet_n,
  input wire logic adc_start,
  input wire logic dac_req,
  input wire logic dac_ack,
  input wire logic fault_led,
  input wire logic rail_en,
  input wire logic ana_sel,
  input wire logic test_flag,
  input wire logic wdt_en,
  input wire logic [3:0] osc_sel,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Power-up
  property p_init;
    $rose(presetn) |=> !wdt_en && osc_sel == 4'h3;
  endproperty
  a_init: assert property (p_init) else $error("init wrong");
  property p_wdt;
    !wdt_en |=> !wdt_en;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog back");
  // ==========================================================
  // Capture
  property p_start;
    adc_start |=> !adc_start;
  endproperty
  a_start: assert property (p_start) else $error("long start");
  // A conversion with the rail off would read garbage
  property p_rail;
    adc_start |-> rail_en;
  endproperty
  a_rail: assert property (p_rail) else $error("rail off");
  property p_led;
    $changed(fault_led) |-> rail_en && !dac_req;
  endproperty
  a_led: assert property (p_led) else $error("stray toggle");
  // ==========================================================
  // Self-test
  property p_entry;
    $rose(test_flag) |-> ana_sel && dac_req;
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry");
  // Two sync stages mean no reaction for two edges
  property p_sync;
    $fell(magnet_n) && !test_flag |=> !test_flag [*2];
  endproperty
  a_sync: assert property (p_sync) else $error("no sync");
  property p_hold;
    dac_req && !dac_ack |=> dac_req;
  endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
  // Main scenarios reached
  c_test: cover property ($rose(test_flag));
  c_led: cover property ($changed(fault_led));
  c_irq: cover property ($rose(irq));
endmodule // fis_seq_props

bind fis_seq fis_seq_props #(.PERIOD_CYC(PERIOD_CYC)) u_props (
  .pclk, .presetn, .magnet_n, .adc_start, .dac_req, .dac_ack,
  .fault_led, .rail_en, .ana_sel, .test_flag, .wdt_en, .osc_sel, .irq
);
`default_nettype wire

/* File: dv/test_fault_indicator_sequencer.sv */
`include "fis_defs.vh"
`default_nettype none
`define check_eq(got, exp) begin checks++; if ((got) !== (exp)) begin \
  num_errors++; $display("unexpected at %0t: %h not %h", $time, got, exp); \
  end end
// ==========================================================
// Self-checking bench of the sequencer
module test_fault_indicator_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_val, r;
  logic pready, pslverr, magnet_n, comp_trip = 0, adc_start, adc_done;
  logic [1:0] adc_chan;
  logic [9:0] adc_data, dac_code;
  logic dac_req, dac_ack, fault_led, rail_en, ana_sel, test_flag, wdt_en;
  logic irq, err, flux_on = 0;
  logic [3:0] osc_sel, lat = 4'h2;
  logic [8:0] i_amp = 9'h0, v_amp = 9'h0, t_amp = 9'h0;
  int num_errors = 0, checks = 0, seed = 33774, n;
  fis_seq #(.PERIOD_CYC(10000)) dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .magnet_n, .comp_trip, .adc_start,
    .adc_chan, .adc_done, .adc_data, .dac_req, .dac_code, .dac_ack,
    .fault_led, .rail_en, .ana_sel, .test_flag, .wdt_en, .osc_sel, .irq
  );
  fis_field_model u_far (
    .pclk, .presetn, .flux_on, .lat, .i_amp, .v_amp, .t_amp, .adc_start,
    .adc_chan, .ana_sel, .dac_req, .adc_done, .adc_data, .dac_ack, .magnet_n
  );
  always #5 pclk = ~pclk;
  // Expected current reading for a path gain
  function automatic logic [15:0] exp_irms(input logic [8:0] a,
                                           input logic hi);
    exp_irms = 16'((32'(a) * (hi ? 32'h100 : 32'h200)) >> 8);
  endfunction
  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll the busy bit until it shows the wanted level
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    do begin
      apb(1'b0, `FIS_REG_STATUS, 32'h0);
      k++;
    end while (rd_val[5] !== lvl && k < 4000);
    if (k >= 4000) num_errors++;
  endtask
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog sized at roughly twice the expected run
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `check_eq(wdt_en, 1'b0)
    `check_eq(osc_sel, `FIS_OSC_8MHZ)
    `check_eq(dac_code, `FIS_DAC_CODE_RST)
    apb(1'b0, `FIS_REG_CTRL, 32'h0);
    `check_eq(rd_val, {17'h0, `FIS_DUTY_RST, 8'h01})
    apb(1'b0, 8'h2c, 32'h0);
    `check_eq(err, 1'b1)
    $display("test init done");
    // Fault on the high-gain path, random amplitudes
    r = $random(seed);
    i_amp <= 9'h101 + {2'b0, r[6:0]};
    v_amp <= r[16:8];
    lat <= r[23:20];
    apb(1'b1, `FIS_REG_INT_MASK, 32'hf);
    wait_busy(1'b1);
    wait_busy(1'b0);
    `check_eq(irq, 1'b1)
    `check_eq(fault_led, 1'b1)
    `check_eq(rd_val[1:0], `FIS_MODE_ACTIVE)
    `check_eq(rd_val[6], 1'b0)
    apb(1'b0, `FIS_REG_I_RMS, 32'h0);
    `check_eq(rd_val[15:0], exp_irms(i_amp, 1'b1))
    apb(1'b0, `FIS_REG_V_RMS, 32'h0);
    `check_eq(rd_val, {23'h0, v_amp})
    apb(1'b0, `FIS_REG_INT_STAT, 32'h0);
    `check_eq(rd_val[3:0], 4'h3)
    apb(1'b1, `FIS_REG_INT_STAT, 32'hf);
    apb(1'b1, `FIS_REG_INT_MASK, 32'h0);
    `check_eq(irq, 1'b0)
    $display("test fault done");
    // Quiet line on the low-gain path, masked, zero duty
    r = $random(seed);
    i_amp <= {3'b0, r[5:0]};
    lat <= r[11:8];
    apb(1'b1, `FIS_REG_CTRL, 32'h1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    `check_eq(rd_val[6], 1'b1)
    `check_eq(irq, 1'b0)
    `check_eq(fault_led, 1'b1)
    `check_eq(rail_en, 1'b0)
    apb(1'b0, `FIS_REG_I_RMS, 32'h0);
    `check_eq(rd_val[15:0], exp_irms(i_amp, 1'b0))
    apb(1'b1, `FIS_REG_INT_STAT, 32'hf);
    $display("test quiet done");
    // Magnet starts a self-test burst on the test waveform; timer off
    // so no queued wake follows the test burst unseen
    apb(1'b1, `FIS_REG_CTRL, 32'h0);
    t_amp <= 9'h180;
    flux_on <= 1'b1;
    for (n = 0; n < 10000 && test_flag !== 1'b1; n++) @(posedge pclk);
    `check_eq(ana_sel, 1'b1)
    flux_on <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    `check_eq(test_flag, 1'b0)
    `check_eq(fault_led, 1'b0)
    apb(1'b0, `FIS_REG_I_RMS, 32'h0);
    `check_eq(rd_val[15:0], exp_irms(t_amp, 1'b1))
    apb(1'b0, `FIS_REG_INT_STAT, 32'h0);
    `check_eq(rd_val[2], 1'b1)
    $display("test self done");
    // Standby: only the comparator or the magnet wakes the block
    apb(1'b1, `FIS_REG_CTRL, 32'h3);
    wait_busy(1'b0);
    apb(1'b1, `FIS_REG_INT_STAT, 32'hf);
    // Frozen block must ignore the trip until enable returns
    ce <= 1'b0;
    comp_trip <= 1'b1;
    repeat (10) @(posedge pclk);
    `check_eq(rail_en, 1'b0)
    ce <= 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
    `check_eq(rd_val[1:0], `FIS_MODE_STBY)
    apb(1'b0, `FIS_REG_INT_STAT, 32'h0);
    `check_eq(rd_val[3], 1'b1)
    comp_trip <= 1'b0;
    $display("test standby done");
    print_verdict();
  end
endmodule // test_fault_indicator_sequencer
`default_nettype wire

/* File: hw/fis_defs.vh */
`ifndef FIS_DEFS_VH
`define FIS_DEFS_VH

// ==========================================================
// Timing
`define FIS_CLK_KHZ 100000
`define FIS_WAKE_PERIOD_MS 1000
`define FIS_WAKE_PERIOD_CYC (`FIS_WAKE_PERIOD_MS * `FIS_CLK_KHZ)
`define FIS_SAMPLE_GAP_CYC 8'h32
`define FIS_SAMPLES 6'h3f

// ==========================================================
// Register offsets (byte addresses)
`define FIS_REG_CTRL 8'h00
`define FIS_REG_STATUS 8'h04
`define FIS_REG_INT_STAT 8'h08
`define FIS_REG_INT_MASK 8'h0c
`define FIS_REG_FAULT_THR 8'h10
`define FIS_REG_XOVER 8'h14
`define FIS_REG_GAIN_LO 8'h18
`define FIS_REG_GAIN_HI 8'h1c
`define FIS_REG_I_RMS 8'h20
`define FIS_REG_V_RMS 8'h24
`define FIS_REG_DAC_CODE 8'h28

// ==========================================================
// Fields and reset values
`define FIS_CTRL_RUN 0
`define FIS_CTRL_STBY 1
`define FIS_DUTY_LSB 8
`define FIS_DUTY_MSB 14
`define FIS_DUTY_RST 7'h10
`define FIS_PCT_STEPS 7'h64
`define FIS_INT_DONE 0
`define FIS_INT_FAULT 1
`define FIS_INT_TEST 2
`define FIS_INT_WAKE 3
`define FIS_FAULT_THR_RST 16'h0100
`define FIS_XOVER_RST 16'h0080
`define FIS_GAIN_LO_RST 16'h0200
`define FIS_GAIN_HI_RST 16'h0100
`define FIS_DAC_CODE_RST 10'h200

// ==========================================================
// Converter and mode encodings
`define FIS_OFFSET_CODE 11'h200
`define FIS_CH_CUR_LO 2'h0
`define FIS_CH_CUR_HI 2'h1
`define FIS_CH_VOLT 2'h2
`define FIS_OSC_8MHZ 4'h3
`define FIS_MODE_ACTIVE 2'h0
`define FIS_MODE_STBY 2'h1
`define FIS_MODE_TEST 2'h2

`endif

/* File: hw/fis_isqrt.v */
`default_nettype none
// ==========================================================
// Bit-serial integer square root, 10 cycles per result
module fis_isqrt (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Request
  input wire go,
  input wire [19:0] radicand,
  // Result
  output reg [9:0] root,
  output reg done
);
  reg [19:0] rad_q;
  reg [3:0] bitp;
  reg busy;
  wire [9:0] trial;
  wire [19:0] tsq;

  // One trial bit per cycle keeps the multiplier small
  assign trial = root | (10'h001 << bitp);
  assign tsq = trial * trial;

  // Restoring search from the top bit down
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rad_q <= 20'h00000;
      bitp <= 4'h0;
      busy <= 1'b0;
      root <= 10'h000;
      done <= 1'b0;
    end else if (ce) begin
      if (go) begin
        rad_q <= radicand;
        root <= 10'h000;
        bitp <= 4'h9;
        busy <= 1'b1;
        done <= 1'b0;
      end else if (busy) begin
        if (tsq <= rad_q)
          root <= trial;
        if (bitp == 4'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          bitp <= bitp - 4'h1;
        end
      end else begin
        done <= 1'b0;
      end
    end
  end
endmodule // fis_isqrt
`default_nettype wire

/* File: hw/fis_seq.v */
`include "fis_defs.vh"
`default_nettype none
// ==========================================================
// Fault indicator mode sequencer with APB register file
module fis_seq #(
  parameter PERIOD_CYC = `FIS_WAKE_PERIOD_CYC
) (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Field inputs
  input wire magnet_n,
  input wire comp_trip,
  // Converter
  output reg adc_start,
  output reg [1:0] adc_chan,
  input wire adc_done,
  input wire [9:0] adc_data,
  // DAC request towards the I2C master
  output reg dac_req,
  output reg [9:0] dac_code,
  input wire dac_ack,
  // Board controls
  output reg fault_led,
  output reg rail_en,
  output reg ana_sel,
  output reg test_flag,
  output reg wdt_en,
  output reg [3:0] osc_sel,
  output reg irq
);
  // Full-width step count, cut to the counter width on purpose
  localparam [31:0] PCT_FULL = PERIOD_CYC / 100 - 1;
  localparam [23:0] PCT_LAST = PCT_FULL[23:0];
  localparam [3:0] S_INIT = 4'h0;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_DAC = 4'h2;
  localparam [3:0] S_TRIG = 4'h3;
  localparam [3:0] S_WAIT = 4'h4;
  localparam [3:0] S_SQI = 4'h5;
  localparam [3:0] S_SQV = 4'h6;
  localparam [3:0] S_SCALE = 4'h7;
  localparam [3:0] S_DECIDE = 4'h8;

  // ==========================================================
  // Declarations
  reg mag_s1, mag_s2, mag_d, cmp_s1, cmp_s2, cmp_d;
  reg ctrl_run, ctrl_stby;
  reg [6:0] duty, pct_idx;
  reg [3:0] int_stat, int_mask, state, ev;
  reg [15:0] fault_thr, xover, gain_lo, gain_hi, i_rms, v_rms;
  reg [23:0] pct_cnt;
  reg pend_tick, pend_cmp, pend_mag;
  reg [7:0] gap_cnt;
  reg [5:0] smp_cnt;
  reg phase, gain_hi_path, sq_go, sq_wait;
  reg [25:0] acc_i, acc_v;
  reg [9:0] root_i, root_v;
  wire [9:0] sq_root, mag_abs;
  wire sq_done, acc_ok, wr, tick, take_mag, take_run;
  wire [10:0] corr;
  wire [19:0] sq, sq_in;
  wire [25:0] prod_i;
  wire [3:0] w1c;

  // ==========================================================
  // Register decode
  function addr_ok(input [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `FIS_REG_DAC_CODE);
  endfunction

  function [31:0] rd_word(input [7:0] a);
    case (a)
      `FIS_REG_CTRL: rd_word = {17'h0, duty, 6'h0, ctrl_stby, ctrl_run};
      `FIS_REG_STATUS: rd_word = {23'h0, cmp_s2, ~mag_s2, gain_hi_path,
        (state != S_IDLE), rail_en, fault_led, test_flag,
        test_flag ? `FIS_MODE_TEST :
        (ctrl_stby ? `FIS_MODE_STBY : `FIS_MODE_ACTIVE)};
      `FIS_REG_INT_STAT: rd_word = {28'h0, int_stat};
      `FIS_REG_INT_MASK: rd_word = {28'h0, int_mask};
      `FIS_REG_FAULT_THR: rd_word = {16'h0, fault_thr};
      `FIS_REG_XOVER: rd_word = {16'h0, xover};
      `FIS_REG_GAIN_LO: rd_word = {16'h0, gain_lo};
      `FIS_REG_GAIN_HI: rd_word = {16'h0, gain_hi};
      `FIS_REG_I_RMS: rd_word = {16'h0, i_rms};
      `FIS_REG_V_RMS: rd_word = {16'h0, v_rms};
      `FIS_REG_DAC_CODE: rd_word = {22'h0, dac_code};
      default: rd_word = 32'h0;
    endcase
  endfunction

  assign acc_ok = psel & penable & pready;
  assign wr = acc_ok & pwrite & addr_ok(paddr);
  assign w1c = (wr && paddr == `FIS_REG_INT_STAT) ? pwdata[3:0] : 4'h0;

  // ==========================================================
  // APB slave: one wait state, pready from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
      if (psel & penable & ~pready)
        prdata <= (pwrite | ~addr_ok(paddr)) ? 32'h0 : rd_word(paddr);
    end
  end

  // Software-written registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_run <= 1'b1;
      ctrl_stby <= 1'b0;
      duty <= `FIS_DUTY_RST;
      int_mask <= 4'h0;
      fault_thr <= `FIS_FAULT_THR_RST;
      xover <= `FIS_XOVER_RST;
      gain_lo <= `FIS_GAIN_LO_RST;
      gain_hi <= `FIS_GAIN_HI_RST;
      dac_code <= `FIS_DAC_CODE_RST;
    end else if (ce && wr) begin
      case (paddr)
        `FIS_REG_CTRL: begin
          ctrl_run <= pwdata[`FIS_CTRL_RUN];
          ctrl_stby <= pwdata[`FIS_CTRL_STBY];
          duty <= pwdata[`FIS_DUTY_MSB:`FIS_DUTY_LSB];
        end
        `FIS_REG_INT_MASK: int_mask <= pwdata[3:0];
        `FIS_REG_FAULT_THR: fault_thr <= pwdata[15:0];
        `FIS_REG_XOVER: xover <= pwdata[15:0];
        `FIS_REG_GAIN_LO: gain_lo <= pwdata[15:0];
        `FIS_REG_GAIN_HI: gain_hi <= pwdata[15:0];
        `FIS_REG_DAC_CODE: dac_code <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      int_stat <= (int_stat & ~w1c) | ev;
      irq <= |(int_stat & int_mask);
    end
  end

  // ==========================================================
  // Input synchronisers; only stage two and its delayed copy feed any logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_s1 <= 1'b1;
      mag_s2 <= 1'b1;
      mag_d <= 1'b1;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_d <= 1'b0;
    end else if (ce) begin
      mag_s1 <= magnet_n;
      mag_s2 <= mag_s1;
      mag_d <= mag_s2;
      cmp_s1 <= comp_trip;
      cmp_s2 <= cmp_s1;
      cmp_d <= cmp_s2;
    end
  end

  // ==========================================================
  // Wake timer: period split into 100 percent steps
  assign tick = (pct_idx == `FIS_PCT_STEPS - 7'h1) && (pct_cnt == PCT_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pct_cnt <= 24'h0;
      pct_idx <= 7'h0;
    end else if (ce) begin
      if (pct_cnt == PCT_LAST) begin
        pct_cnt <= 24'h0;
        pct_idx <= tick ? 7'h0 : pct_idx + 7'h1;
      end else begin
        pct_cnt <= pct_cnt + 24'h1;
      end
    end
  end

  // Pending wake causes; set wins over the take
  assign take_mag = (state == S_IDLE) && pend_mag;
  assign take_run = (state == S_IDLE) && !pend_mag && (pend_tick | pend_cmp);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_tick <= 1'b0;
      pend_cmp <= 1'b0;
      pend_mag <= 1'b0;
    end else if (ce) begin
      // Hall output may lag by one refresh; an edge is enough
      pend_mag <= (mag_d & ~mag_s2) | (pend_mag & ~take_mag);
      pend_cmp <= (ctrl_stby & cmp_s2 & ~cmp_d) |
                  (pend_cmp & ~take_run);
      pend_tick <= (tick & ctrl_run & ~ctrl_stby) |
                   (pend_tick & ~take_run);
    end
  end

  // ==========================================================
  // Sample datapath: offset removal and squaring
  assign corr = {1'b0, adc_data} - `FIS_OFFSET_CODE;
  assign mag_abs = corr[10] ? ~corr[9:0] + 10'h001 : corr[9:0];
  assign sq = mag_abs * mag_abs;
  assign sq_in = (state == S_SQI) ? acc_i[25:6] : acc_v[25:6];
  assign prod_i = root_i * (gain_hi_path ? gain_hi : gain_lo);

  fis_isqrt u_isqrt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .go(sq_go),
    .radicand(sq_in),
    .root(sq_root),
    .done(sq_done)
  );

  // ==========================================================
  // Sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_INIT;
      gap_cnt <= 8'h0;
      smp_cnt <= 6'h0;
      phase <= 1'b0;
      gain_hi_path <= 1'b1;
      sq_go <= 1'b0;
      sq_wait <= 1'b0;
      acc_i <= 26'h0;
      acc_v <= 26'h0;
      root_i <= 10'h0;
      root_v <= 10'h0;
      i_rms <= 16'h0;
      v_rms <= 16'h0;
      ev <= 4'h0;
      adc_start <= 1'b0;
      adc_chan <= `FIS_CH_CUR_HI;
      dac_req <= 1'b0;
      fault_led <= 1'b0;
      rail_en <= 1'b0;
      ana_sel <= 1'b0;
      test_flag <= 1'b0;
      wdt_en <= 1'b1;
      osc_sel <= 4'h0;
    end else if (ce) begin
      ev <= 4'h0;
      adc_start <= 1'b0;
      sq_go <= 1'b0;
      // Rail only inside the active window or a running burst
      if (state != S_INIT)
        rail_en <= (state != S_IDLE) | take_mag | take_run |
                   (ctrl_run & ~ctrl_stby & (pct_idx < duty));
      case (state)
        S_INIT: begin
          wdt_en <= 1'b0;
          osc_sel <= `FIS_OSC_8MHZ;
          state <= S_IDLE;
        end
        S_IDLE: begin
          acc_i <= 26'h0;
          acc_v <= 26'h0;
          smp_cnt <= 6'h0;
          phase <= 1'b0;
          gap_cnt <= 8'h0;
          if (take_mag) begin
            test_flag <= 1'b1;
            ana_sel <= 1'b1;
            dac_req <= 1'b1;
            ev[`FIS_INT_TEST] <= 1'b1;
            state <= S_DAC;
          end else if (take_run) begin
            ev[`FIS_INT_WAKE] <= pend_cmp;
            state <= S_TRIG;
          end
        end
        S_DAC: begin
          if (dac_ack) begin
            dac_req <= 1'b0;
            state <= S_TRIG;
          end
        end
        S_TRIG: begin
          // Fixed spacing stands in for the conversion timer
          if (gap_cnt == `FIS_SAMPLE_GAP_CYC) begin
            gap_cnt <= 8'h0;
            adc_start <= 1'b1;
            adc_chan <= phase ? `FIS_CH_VOLT :
                        (gain_hi_path ? `FIS_CH_CUR_HI : `FIS_CH_CUR_LO);
            state <= S_WAIT;
          end else begin
            gap_cnt <= gap_cnt + 8'h1;
          end
        end
        S_WAIT: begin
          if (adc_done) begin
            phase <= ~phase;
            if (phase) begin
              acc_v <= acc_v + {6'h0, sq};
              smp_cnt <= smp_cnt + 6'h1;
              state <= (smp_cnt == `FIS_SAMPLES) ? S_SQI : S_TRIG;
            end else begin
              acc_i <= acc_i + {6'h0, sq};
              state <= S_TRIG;
            end
          end
        end
        S_SQI: begin
          if (!sq_wait) begin
            sq_go <= 1'b1;
            sq_wait <= 1'b1;
          end else if (sq_done) begin
            root_i <= sq_root;
            sq_wait <= 1'b0;
            state <= S_SQV;
          end
        end
        S_SQV: begin
          if (!sq_wait) begin
            sq_go <= 1'b1;
            sq_wait <= 1'b1;
          end else if (sq_done) begin
            root_v <= sq_root;
            sq_wait <= 1'b0;
            state <= S_SCALE;
          end
        end
        S_SCALE: begin
          i_rms <= prod_i[23:8];
          v_rms <= {6'h0, root_v};
          ev[`FIS_INT_DONE] <= 1'b1;
          state <= S_DECIDE;
        end
        S_DECIDE: begin
          // Self-test passes when the emulated fault is seen
          if (i_rms > fault_thr) begin
            fault_led <= ~fault_led;
            ev[`FIS_INT_FAULT] <= 1'b1;
          end
          gain_hi_path <= ~(i_rms > xover);
          test_flag <= 1'b0;
          ana_sel <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fis_seq
`default_nettype wire
